// file: frtc_counter.sv
// free-running 16-bit timer counter with modulus variant and interrupt output
// What this block does
// - freeze request with honor bit set holds prescaler and counter
// - host register access works unchanged while frozen
// - pin level status keeps tracking the pin while frozen
// - honor bit clear ignores freeze request entirely
// - processor stop does not stop the timer
// - prescaler gives five fixed enables and one selectable of four ratios
// - no prescaler tap counts until software sets prescaler run; pin edges count without it
// - wrap from all ones to zero sets sticky overflow flag
// - counter reads live; host write loads it at once
// - reset clears the counter
// - host write of zero over all ones sets no flag
// - three-bit select picks six taps or pin rising or falling edge
// - select change cannot cause a spurious external count
// - pin is synchronised and its level is a status bit
// - two drive bits choose time-base bus output
// - request raised when flag set and level nonzero
// - contend only when level exceeds processor priority mask
// - arbitration number is three config bits plus own top bit
// - vector is two config bits over submodule number
// - unused bits read zero and ignore writes
// - modulus latch reloads counter on overflow or load-pin edge
// - counter write loads counter and modulus latch together
// - reset clears latch; zero latch gives free-running behaviour
// - all-ones latch sets overflow on every count pulse
`timescale 1ns/10ps
`default_nettype none
module frtc_counter
  import frtc_pkg::*;
#(
  parameter bit MODULUS_EN = 1'b1
)(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  input  wire logic        freezeReq,
  input  wire logic        freezeHonor,
  input  wire logic        prescalerRun,
  input  wire logic [1:0]  prescalerDivSel,
  input  wire logic [2:0]  clockSel,
  input  wire logic        driveBusFirst,
  input  wire logic        driveBusSecond,
  input  wire logic [2:0]  irqLevel,
  input  wire logic        arbNumberTopBit,
  input  wire logic [2:0]  arbNumberLow,
  input  wire logic [1:0]  isrNumberUpper,
  input  wire logic [2:0]  cpuPriorityMask,
  input  wire logic        extCountPin,
  input  wire logic        modLoadPin,
  input  wire logic [1:0]  modLoadEdge,
  input  wire logic        cntWrite,
  input  wire logic [15:0] cntWrData,
  input  wire logic        modWrite,
  input  wire logic [15:0] modWrData,
  input  wire logic        ovfClear,
  output logic      [15:0] cntValue,
  output logic      [15:0] modValue,
  output logic             overflowFlag,
  output logic             extPinLevel,
  output logic             modPinLevel,
  output logic      [15:0] timeBusFirst,
  output logic             timeBusFirstEn,
  output logic      [15:0] timeBusSecond,
  output logic             timeBusSecondEn,
  output logic             irqRequest,
  output logic             irqContend,
  output logic      [3:0]  arbNumber,
  output logic      [7:0]  irqVector
);
  initial begin
    if (CNT_W != 16) $error("frtc_counter serves a 16-bit counter only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock enable, freeze and prescaler
  logic                frozen;
  logic                runEn;
  logic [NUM_PCLK-1:0] pclkEn;

  assign frozen = freezeReq && freezeHonor;
  assign runEn  = prescalerRun && !frozen;  // stop of cpu never reaches here

  frtc_prescaler u_prescaler (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .runEn   (runEn),
    .divSel  (prescalerDivSel),
    .pclkEn  (pclkEn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect; keep running while frozen
  logic [2:0] extSync_q;
  logic [2:0] modSync_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      extSync_q <= 3'h0;
      modSync_q <= 3'h0;
    end else if (clkEn) begin
      extSync_q <= {extSync_q[1:0], extCountPin};
      modSync_q <= {modSync_q[1:0], modLoadPin};
    end
  end
  logic extRise;
  logic extFall;
  logic modRise;
  logic modFall;
  assign extRise = extSync_q[1] && !extSync_q[2];
  assign extFall = !extSync_q[1] && extSync_q[2];
  assign modRise = modSync_q[1] && !modSync_q[2];
  assign modFall = !modSync_q[1] && modSync_q[2];

  // mask external edges for a short guard after a select change
  logic [2:0] clkSelPrev_q;
  logic [1:0] guardCnt_q;
  logic [1:0] guardCnt_d;
  logic       selChanged;
  assign selChanged = (clockSel != clkSelPrev_q);
  assign guardCnt_d = selChanged ? 2'(EDGE_GUARD_CYC) :
                      (guardCnt_q != 2'h0) ? guardCnt_q - 2'h1 : 2'h0;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      clkSelPrev_q <= 3'h0;
      guardCnt_q   <= 2'h0;
    end else if (clkEn) begin
      clkSelPrev_q <= clockSel;
      guardCnt_q   <= guardCnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection, one enable per count
  logic [7:0] pclkPad;
  logic extGate;
  logic countTick;
  assign pclkPad = {2'b00, pclkEn}; // padded so every select value indexes in range
  assign extGate = !selChanged && (guardCnt_q == 2'h0) && !frozen && clkEn;
  assign countTick = (clockSel == CLK_SEL_RISE) ? (extRise && extGate) :
                     (clockSel == CLK_SEL_FALL) ? (extFall && extGate) :
                     pclkPad[clockSel];

  ////////////////////////////////////////////////////////////////////////////
  // counter, modulus latch and overflow flag
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] mod_q;
  logic [15:0] mod_d;
  logic        ovf_q;
  logic        ovf_d;
  logic        wrapEvt;
  logic        loadPinEvt;
  logic        modLoadHit;
  logic [15:0] reloadVal;

  assign wrapEvt    = countTick && (cnt_q == CNT_ALL_ONES);
  assign modLoadHit = ((modLoadEdge == LOAD_EDGE_RISE) && modRise) ||
                      ((modLoadEdge == LOAD_EDGE_FALL) && modFall) ||
                      ((modLoadEdge == LOAD_EDGE_BOTH) && (modRise || modFall));
  assign loadPinEvt = MODULUS_EN && modLoadHit && !frozen;
  assign reloadVal  = MODULUS_EN ? mod_q : CNT_RESET; // zero latch acts free-running

  // host write first, then reload, then increment
  assign cnt_d = cntWrite   ? cntWrData :
                 (wrapEvt || loadPinEvt) ? reloadVal :
                 countTick  ? cnt_q + 16'h0001 : cnt_q;
  assign mod_d = (MODULUS_EN && cntWrite) ? cntWrData :
                 (MODULUS_EN && modWrite) ? modWrData : mod_q;
  // host write has priority, so a zero write over all ones sets no flag
  // hardware set wins over software clear
  assign ovf_d = (wrapEvt && !cntWrite) ? 1'b1 : (ovfClear ? 1'b0 : ovf_q);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_q <= CNT_RESET;
      mod_q <= MOD_RESET;
      ovf_q <= 1'b0;
    end else if (clkEn) begin
      cnt_q <= cnt_d;
      mod_q <= mod_d;
      ovf_q <= ovf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: bus drive, interrupt, arbitration and vector
  logic        irqReq_d;
  logic        contend_d;
  logic [15:0] busFirst_q;
  logic [15:0] busSecond_q;
  logic        busFirstEn_q;
  logic        busSecondEn_q;
  logic        irqReq_q;
  logic        contend_q;
  logic [3:0]  arb_q;
  logic [7:0]  vec_q;
  logic        extLvl_q;
  logic        modLvl_q;

  assign irqReq_d  = ovf_d && (irqLevel != IRQ_LEVEL_OFF);
  assign contend_d = irqReq_d && (irqLevel > cpuPriorityMask);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busFirst_q    <= 16'h0000;
      busSecond_q   <= 16'h0000;
      busFirstEn_q  <= 1'b0;
      busSecondEn_q <= 1'b0;
      irqReq_q      <= 1'b0;
      contend_q     <= 1'b0;
      arb_q         <= 4'h0;
      vec_q         <= 8'h00;
      extLvl_q      <= 1'b0;
      modLvl_q      <= 1'b0;
    end else if (clkEn) begin
      busFirst_q    <= driveBusFirst ? cnt_d : 16'h0000;
      busSecond_q   <= driveBusSecond ? cnt_d : 16'h0000;
      busFirstEn_q  <= driveBusFirst;
      busSecondEn_q <= driveBusSecond;
      irqReq_q      <= irqReq_d;
      contend_q     <= contend_d;
      arb_q         <= {arbNumberTopBit, arbNumberLow};
      vec_q         <= {isrNumberUpper, SUBMODULE_NUM};
      extLvl_q      <= extSync_q[1];
      modLvl_q      <= modSync_q[1];
    end
  end

  assign cntValue        = cnt_q;
  assign modValue        = MODULUS_EN ? mod_q : 16'h0000;
  assign overflowFlag    = ovf_q;
  assign extPinLevel     = extLvl_q;
  assign modPinLevel     = modLvl_q;
  assign timeBusFirst    = busFirst_q;
  assign timeBusFirstEn  = busFirstEn_q;
  assign timeBusSecond   = busSecond_q;
  assign timeBusSecondEn = busSecondEn_q;
  assign irqRequest      = irqReq_q;
  assign irqContend      = contend_q;
  assign arbNumber       = arb_q;
  assign irqVector       = vec_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  freeze_hold_a: assert property (clkEn && frozen && !cntWrite && !$past(cntWrite)
    |=> $stable(cnt_q)) else $error("counter moved while frozen");
  honor_off_a: assert property ((clkEn && freezeReq && !freezeHonor && prescalerRun) [*3]
    |-> pclkEn[0] != $past(pclkEn[0])) else $error("freeze request stopped prescaler");
  no_run_a: assert property (clkEn && !prescalerRun && !cntWrite && !loadPinEvt
    && clockSel < 3'h6 |=> cnt_q == $past(cnt_q)) else $error("counted without run");
  wrap_flag_a: assert property (clkEn && wrapEvt && !cntWrite |=> ovf_q)
    else $error("wrap did not set flag");
  write_load_a: assert property (clkEn && cntWrite |=> cnt_q == $past(cntWrData)
    && (!MODULUS_EN || mod_q == $past(cntWrData))) else $error("write not loaded");
  zero_write_a: assert property (clkEn && cntWrite && !ovf_q && !ovfClear |=> !ovf_q)
    else $error("write set overflow");
  irq_follow_a: assert property (clkEn |=> irqRequest == (ovf_q && irqLevel != 3'h0)
    || !$stable(irqLevel) || !$past(clkEn)) else $error("request mismatch");
  pin_track_a: assert property (clkEn ##1 clkEn ##1 clkEn ##1 1'b1
    |-> extPinLevel == $past(extCountPin, 3)) else $error("pin level lost");
  vector_a: assert property (clkEn |=> irqVector == {$past(isrNumberUpper), 6'h0c})
    else $error("bad vector");
  guard_a: assert property (clkEn && selChanged |-> !(extRise || extFall) || !countTick
    || clockSel < 3'h6) else $error("edge counted on select change");

  wrap_c: cover property (clkEn && wrapEvt);
  ext_c: cover property (clkEn && countTick && clockSel == CLK_SEL_RISE);
  freeze_c: cover property (clkEn && frozen && prescalerRun);
  reload_c: cover property (clkEn && loadPinEvt);
endmodule : frtc_counter
`default_nettype wire

// file: frtc_pin_model.sv
// external count pin source standing in for the far-side pulse generator
`timescale 1ns/10ps
`default_nettype none
module frtc_pin_model (
  input  wire logic ref_clk,
  output logic      pinOut
);
  // the pin idles low between bursts
  initial pinOut = 1'b0;
  // n pulses, each level held for half cycles and never under two
  task automatic send(input int n, input int half);
    int h;
    h = (half < 2) ? 2 : half;
    repeat (n) begin
      @(posedge ref_clk) pinOut <= 1'b1;
      repeat (h - 1) @(posedge ref_clk);
      @(posedge ref_clk) pinOut <= 1'b0;
      repeat (h - 1) @(posedge ref_clk);
    end
  endtask : send
endmodule : frtc_pin_model
`default_nettype wire

// file: frtc_pkg.sv
// constants shared by the free-running timer counter files
package frtc_pkg;
  localparam int unsigned CNT_W          = 16;
  localparam logic [15:0] CNT_RESET      = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES   = 16'hffff;
  localparam logic [15:0] MOD_RESET      = 16'h0000;
  localparam int unsigned NUM_PCLK       = 6;
  localparam int unsigned FIXED_STAGES   = 5;
  localparam int unsigned FIXED_STEP_LOG = 1;    // each fixed stage divides by two
  localparam int unsigned SEL_DIV_W      = 2;
  localparam int unsigned SEL_CNT_W      = 10;
  localparam logic [9:0]  SEL_DIV_0      = 10'h03f; // divide by 64
  localparam logic [9:0]  SEL_DIV_1      = 10'h07f; // divide by 128
  localparam logic [9:0]  SEL_DIV_2      = 10'h0ff; // divide by 256
  localparam logic [9:0]  SEL_DIV_3      = 10'h1ff; // divide by 512
  localparam logic [2:0]  CLK_SEL_RISE   = 3'h6;
  localparam logic [2:0]  CLK_SEL_FALL   = 3'h7;
  localparam logic [2:0]  IRQ_LEVEL_OFF  = 3'h0;
  localparam logic [5:0]  SUBMODULE_NUM  = 6'h0c;
  localparam int unsigned EDGE_GUARD_CYC = 2;    // cycles of external edge masking
  localparam logic [1:0]  LOAD_EDGE_RISE = 2'h1;
  localparam logic [1:0]  LOAD_EDGE_FALL = 2'h2;
  localparam logic [1:0]  LOAD_EDGE_BOTH = 2'h3;
endpackage : frtc_pkg

// file: frtc_prescaler.sv
// prescaler producing six single-cycle count enables
`timescale 1ns/10ps
`default_nettype none
module frtc_prescaler
  import frtc_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic                 clkEn,
  input  wire logic                 runEn,
  input  wire logic [SEL_DIV_W-1:0] divSel,
  output logic      [NUM_PCLK-1:0]  pclkEn
);
  logic [SEL_CNT_W-1:0] divCnt_q;
  logic [SEL_CNT_W-1:0] divCnt_d;
  logic [SEL_CNT_W-1:0] selMask;
  logic [NUM_PCLK-1:0]  pclk_d;
  logic [NUM_PCLK-1:0]  pclk_q;

  // divider chain advances only while running and not frozen
  assign divCnt_d = divCnt_q + 10'h001;
  assign selMask  = (divSel == 2'h0) ? SEL_DIV_0 :
                    (divSel == 2'h1) ? SEL_DIV_1 :
                    (divSel == 2'h2) ? SEL_DIV_2 : SEL_DIV_3;

  // five fixed taps: divide by 2, 4, 8, 16, 32
  genvar gi;
  generate
    for (gi = 0; gi < FIXED_STAGES; gi++) begin : g_tap
      localparam logic [SEL_CNT_W-1:0] TapMask =
        SEL_CNT_W'((1 << ((gi + 1) * FIXED_STEP_LOG)) - 1);
      assign pclk_d[gi] = runEn && ((divCnt_q & TapMask) == TapMask);
    end
  endgenerate
  assign pclk_d[NUM_PCLK-1] = runEn && ((divCnt_q & selMask) == selMask);

  // enables are registered so each lasts one clock
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      divCnt_q <= '0;
      pclk_q   <= '0;
    end else if (clkEn) begin
      divCnt_q <= runEn ? divCnt_d : divCnt_q;
      pclk_q   <= pclk_d;
    end
  end
  assign pclkEn = pclk_q & {NUM_PCLK{clkEn && runEn}}; // a stale enable dies with run
endmodule : frtc_prescaler
`default_nettype wire

// file: frtc_tb.sv
// self-checking bench for the free-running timer counter
`timescale 1ns/10ps
`default_nettype none
module testbench
  import frtc_pkg::*;
;
  localparam int WATCH = 20000;
  logic        ref_clk, rst_b, clkEn, freezeReq, freezeHonor, prescalerRun, driveBusFirst;
  logic        driveBusSecond, arbNumberTopBit, extCountPin, modLoadPin, cntWrite, modWrite;
  logic        ovfClear, overflowFlag, extPinLevel, modPinLevel, timeBusFirstEn;
  logic        timeBusSecondEn, irqRequest, irqContend;
  logic [1:0]  prescalerDivSel, isrNumberUpper, modLoadEdge;
  logic [2:0]  clockSel, irqLevel, arbNumberLow, cpuPriorityMask;
  logic [3:0]  arbNumber;
  logic [7:0]  irqVector;
  logic [15:0] cntWrData, modWrData, cntValue, modValue, timeBusFirst, timeBusSecond;
  int          failures, numChecks, seed, mCnt, mLat, mFlag, v;

  frtc_counter #(.MODULUS_EN(1'b1)) DUT (
    .ref_clk, .rst_b, .clkEn, .freezeReq, .freezeHonor, .prescalerRun, .prescalerDivSel,
    .clockSel, .driveBusFirst, .driveBusSecond, .irqLevel, .arbNumberTopBit, .arbNumberLow,
    .isrNumberUpper, .cpuPriorityMask, .extCountPin, .modLoadPin, .modLoadEdge, .cntWrite,
    .cntWrData, .modWrite, .modWrData, .ovfClear, .cntValue, .modValue, .overflowFlag,
    .extPinLevel, .modPinLevel, .timeBusFirst, .timeBusFirstEn, .timeBusSecond,
    .timeBusSecondEn, .irqRequest, .irqContend, .arbNumber, .irqVector);
  frtc_pin_model pinSrc (.ref_clk, .pinOut(extCountPin));

  // system clock
  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // compares, one per kind of result
  task automatic chk_val(string what, logic [15:0] exp, logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : chk_val
  task automatic chk_bit(string what, logic exp, logic got);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %b got %b", what, exp, got);
    end
  endtask : chk_bit
  // wait n edges, then let their updates settle
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // host access: 0 counter write, 1 latch write, 2 flag clear
  task automatic host(int kind, logic [15:0] d);
    @(posedge ref_clk) begin
      cntWrite <= (kind == 0);
      modWrite <= (kind == 1);
      ovfClear <= (kind == 2);
      cntWrData <= d;
      modWrData <= d;
    end
    @(posedge ref_clk) begin
      cntWrite <= 1'b0;
      modWrite <= 1'b0;
      ovfClear <= 1'b0;
    end
    #1;
    if (kind == 0) mCnt = d;
    if (kind != 2) mLat = d;
    else mFlag = 0;
  endtask : host
  // model one count: a wrap reloads the counter from the latch and sets the flag
  task automatic bump();
    if (mCnt == 'hffff) begin
      mCnt = mLat;
      mFlag = 1;
    end else mCnt = mCnt + 1;
  endtask : bump
  // wait for one count and advance the model with it
  task automatic step();
    int k;
    logic [15:0] old;
    old = cntValue;
    k = 0;
    while (cntValue === old && k < 200) begin
      tick(1);
      k++;
    end
    chk_bit("step", 1'b1, k < 200);
    bump();
    chk_val("cnt", mCnt[15:0], cntValue);
    chk_bit("flag", mFlag[0], overflowFlag);
  endtask : step
  task automatic done(string n);
    $display("test %s done", n);
  endtask : done
  task automatic give_verdict();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {ref_clk, rst_b, freezeReq, freezeHonor, prescalerRun, driveBusFirst, driveBusSecond} = '0;
    {arbNumberTopBit, modLoadPin, cntWrite, modWrite, ovfClear, prescalerDivSel} = '0;
    {isrNumberUpper, modLoadEdge, clockSel, irqLevel, arbNumberLow, cpuPriorityMask} = '0;
    {cntWrData, modWrData, failures, numChecks, mCnt, mLat, mFlag} = '0;
    clkEn = 1'b1;
    seed = 46881;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    tick(50);
    chk_val("cnt", 16'h0000, cntValue);
    chk_val("mod", 16'h0000, modValue);
    chk_bit("flag", 1'b0, overflowFlag);
    done("reset");
    @(posedge ref_clk) irqLevel <= 3'h3;
    host(0, 16'hffff);
    chk_val("cnt", 16'hffff, cntValue);
    chk_val("mod", 16'hffff, modValue);
    host(0, 16'h0000);
    tick(2);
    chk_bit("flag", 1'b0, overflowFlag);
    chk_bit("irq", 1'b0, irqRequest);
    done("write");
    // every prescaler tap, rate over a fixed span
    for (int s = 0; s < 9; s++) begin
      @(posedge ref_clk) begin
        prescalerRun <= 1'b1;
        clockSel <= (s < 5) ? 3'(s) : 3'h5;
        prescalerDivSel <= (s < 5) ? 2'($random(seed)) : 2'(s - 5);
      end
      host(0, 16'h0000);
      tick(1024);
      v = 1024 / ((s < 5) ? (2 << s) : (64 << (s - 5)));
      chk_bit("rate", 1'b1, (cntValue + 1 >= v) && (cntValue <= v + 1));
    end
    done("taps");
    // overflow and interrupt fields at every level
    @(posedge ref_clk) clockSel <= 3'h0;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk) begin
        irqLevel <= 3'(i);
        {cpuPriorityMask, arbNumberLow, arbNumberTopBit, isrNumberUpper} <= 9'($random(seed));
      end
      host(0, 16'hfffe);
      repeat (3) step();
      chk_bit("req", i != 0, irqRequest);
      chk_bit("contend", i > cpuPriorityMask, irqContend);
      chk_val("arb", {arbNumberTopBit, arbNumberLow}, arbNumber);
      chk_val("vector", {isrNumberUpper, SUBMODULE_NUM}, irqVector);
    end
    done("irq");
    // freeze holds counts, host access and pin status still work
    @(posedge ref_clk) {freezeReq, freezeHonor} <= 2'h3;
    tick(2);
    v = cntValue;
    tick(40);
    chk_val("frozen", v[15:0], cntValue);
    host(0, 16'h1234);
    tick(20);
    chk_val("frozen", 16'h1234, cntValue);
    fork
      pinSrc.send(1, 8);
    join_none
    tick(6);
    chk_bit("pin", 1'b1, extPinLevel);
    tick(10);
    chk_bit("pin", 1'b0, extPinLevel);
    @(posedge ref_clk) freezeHonor <= 1'b0;
    repeat (2) step();
    @(posedge ref_clk) freezeReq <= 1'b0;
    // clock enable low freezes every register, host writes included
    @(posedge ref_clk) clkEn <= 1'b0;
    tick(2);
    v = cntValue;
    @(posedge ref_clk) cntWrite <= 1'b1;
    tick(20);
    chk_val("clken", v[15:0], cntValue);
    @(posedge ref_clk) begin
      clkEn <= 1'b1;
      cntWrite <= 1'b0;
    end
    done("freeze");
    // external edges, prompt on rise and slow on fall
    for (int e = 0; e < 2; e++) begin
      @(posedge ref_clk) clockSel <= 3'(6 + e);
      host(0, 16'($random(seed)));
      tick(4);
      pinSrc.send(5, 2 + 3 * e);
      tick(6);
      repeat (5) bump();
      chk_val("events", mCnt[15:0], cntValue);
    end
    done("external");
    // load pin reloads on the chosen edges only
    for (int e = 1; e < 4; e++) begin
      @(posedge ref_clk) modLoadEdge <= 2'(e);
      host(0, 16'(16'h1111 * e));
      host(1, 16'h0abc);
      chk_val("hold", mCnt[15:0], cntValue);
      @(posedge ref_clk) modLoadPin <= 1'b1;
      tick(5);
      if (e != 2) mCnt = mLat;
      chk_val("reload", mCnt[15:0], cntValue);
      chk_bit("loadpin", 1'b1, modPinLevel);
      host(1, 16'h0def);
      @(posedge ref_clk) modLoadPin <= 1'b0;
      tick(5);
      if (e != 1) mCnt = mLat;
      chk_val("reload", mCnt[15:0], cntValue);
      chk_bit("loadpin", 1'b0, modPinLevel);
    end
    done("loadpin");
    // all-ones latch flags every count
    @(posedge ref_clk) {clockSel, freezeHonor} <= 4'h1;
    host(0, 16'hffff);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk) freezeReq <= 1'b1;
      host(2, 16'h0000);
      tick(1);
      chk_bit("flag", 1'b0, overflowFlag);
      @(posedge ref_clk) freezeReq <= 1'b0;
      tick(4);
      chk_bit("flag", 1'b1, overflowFlag);
      chk_val("cnt", 16'hffff, cntValue);
    end
    done("modulus");
    // time-base bus drive in every combination
    @(posedge ref_clk) freezeReq <= 1'b1;
    host(0, 16'($random(seed)));
    for (int b = 0; b < 4; b++) begin
      @(posedge ref_clk) {driveBusSecond, driveBusFirst} <= 2'(b);
      tick(2);
      chk_val("busA", b[0] ? mCnt[15:0] : 16'h0000, timeBusFirst);
      chk_val("busB", b[1] ? mCnt[15:0] : 16'h0000, timeBusSecond);
      chk_bit("busAen", b[0], timeBusFirstEn);
      chk_bit("busBen", b[1], timeBusSecondEn);
    end
    done("buses");
    give_verdict();
  end

  // watchdog cutting a hung run short
  initial begin
    repeat (WATCH) @(posedge ref_clk);
    failures++;
    $display("CHECK FAILED watchdog exp finish got timeout");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
